// ### common/ums_regs.vh
// Purpose: Register map, field positions and reset values of the UART mode/status block
// Assumes: APB with 32-bit data; printed offsets are word indexes
// Notes:   Byte address of a register is four times its index
`ifndef UMS_REGS_VH
`define UMS_REGS_VH

// ****************************************
// Register indexes and address width
// ****************************************
`define UMS_IDX_MODE        18'h0FF70
`define UMS_IDX_BAUD        18'h0FF71
`define UMS_IDX_RXBUF       18'h0FF72
`define UMS_IDX_RXERR       18'h0FF73
`define UMS_IDX_TXSHIFT     18'h0FF74
`define UMS_ADDR_W          20

// ****************************************
// Mode register fields
// ****************************************
`define UMS_MODE_POWER      7
`define UMS_MODE_TXEN       6
`define UMS_MODE_RXEN       5
`define UMS_MODE_PS_HI      4
`define UMS_MODE_PS_LO      3
`define UMS_MODE_CL         2
`define UMS_MODE_SL         1
`define UMS_MODE_RST        8'h01

// ****************************************
// Status, buffer and divider fields
// ****************************************
`define UMS_ERR_PARITY      2
`define UMS_ERR_FRAMING     1
`define UMS_ERR_OVERRUN     0
`define UMS_ERR_RST         3'h0
`define UMS_BUF_RST         8'hFF
`define UMS_BAUD_RST        5'h1F
`define UMS_BAUD_MIN        5'h08

`endif

// ### core/ums_top.v
// Purpose: Serial port mode register, receive error status, transmitter and receiver
// Assumes: Base clock is clk; APB slave with wait states; serial_rx_pin is asynchronous
// Notes:   Power-off acts as a reset of the whole serial circuit inside this clock domain
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ums_regs.vh"

module ums_top (
	input  wire                   clk,
	input  wire                   rst,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`UMS_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   serial_rx_pin,
	output reg                    serial_tx_pin,
	output reg                    rx_err_irq,
	output reg                    tx_done_irq,
	output reg                    rx_done_irq
);

// ****************************************
// Registers and state
// ****************************************
localparam RX_IDLE   = 3'd0;
localparam RX_START  = 3'd1;
localparam RX_DATA   = 3'd2;
localparam RX_PARITY = 3'd3;
localparam RX_STOP   = 3'd4;

reg  [7:0]  mode_q;
reg  [4:0]  baud_q;
reg  [2:0]  err_q;
reg  [7:0]  rxbuf_q;
reg         rxbuf_full_q;
reg  [7:0]  txhold_q;
reg         wait_done_q;
reg         rx_meta_q;
reg         rx_sync_q;
reg  [2:0]  rx_state_q;
reg  [5:0]  rx_cnt_q;
reg  [3:0]  rx_bit_q;
reg  [7:0]  rx_sr_q;
reg         rx_par_q;
reg  [10:0] tx_sr_q;
reg  [3:0]  tx_left_q;
reg  [5:0]  tx_cnt_q;

wire        power   = mode_q[`UMS_MODE_POWER];
wire        tx_en   = mode_q[`UMS_MODE_TXEN];
wire        rx_en   = mode_q[`UMS_MODE_RXEN];
wire [1:0]  par_sel = {mode_q[`UMS_MODE_PS_HI], mode_q[`UMS_MODE_PS_LO]};
wire        cl8     = mode_q[`UMS_MODE_CL];
wire        sl2     = mode_q[`UMS_MODE_SL];
wire        pwr_rst = rst | ~power;
wire        tx_rst  = pwr_rst | ~tx_en;
wire        rx_rst  = pwr_rst | ~rx_en;

// Divider settings below eight are prohibited; clamp so the bit clock never stalls
wire [4:0]  k_eff   = (baud_q < `UMS_BAUD_MIN) ? `UMS_BAUD_MIN : baud_q;
wire [5:0]  bit_end = {k_eff, 1'b0} - 6'd1;
wire [5:0]  mid_pt  = {1'b0, k_eff} - 6'd1;

// ****************************************
// APB slave
// ****************************************
wire [17:0] idx      = paddr[`UMS_ADDR_W-1:2];
wire        access   = psel & penable;
wire        done     = access & pready;
wire        hit_mode = (idx == `UMS_IDX_MODE);
wire        hit_baud = (idx == `UMS_IDX_BAUD);
wire        hit_rxb  = (idx == `UMS_IDX_RXBUF);
wire        hit_err  = (idx == `UMS_IDX_RXERR);
wire        hit_txs  = (idx == `UMS_IDX_TXSHIFT);
wire        hit_any  = hit_mode | hit_baud | hit_rxb | hit_err | hit_txs;
wire        wr_done  = done & pwrite;
wire        rd_done  = done & ~pwrite;
wire        rd_err   = rd_done & hit_err;
wire        rd_rxb   = rd_done & hit_rxb;
wire        wr_txs   = wr_done & hit_txs;

reg  [31:0] rdata_d;
always @* begin
	rdata_d = 32'h0000_0000;
	if (hit_mode) begin
		rdata_d[7:0] = mode_q;
	end else if (hit_baud) begin
		rdata_d[4:0] = baud_q;
	end else if (hit_rxb) begin
		rdata_d[7:0] = rxbuf_q;
	end else if (hit_err) begin
		rdata_d[2:0] = err_q;
	end
end

// Answer comes one cycle into the access phase; status register reads take one more
always @(posedge clk) begin
	if (rst) begin
		pready      <= 1'b0;
		pslverr     <= 1'b0;
		prdata      <= 32'h0000_0000;
		wait_done_q <= 1'b0;
	end else if (access & ~pready) begin
		if (hit_err & ~pwrite & ~wait_done_q) begin
			wait_done_q <= 1'b1;
		end else begin
			pready      <= 1'b1;
			pslverr     <= ~hit_any;
			prdata      <= pwrite ? 32'h0000_0000 : rdata_d;
			wait_done_q <= 1'b0;
		end
	end else begin
		pready      <= 1'b0;
		pslverr     <= 1'b0;
		wait_done_q <= 1'b0;
	end
end

always @(posedge clk) begin
	if (rst) begin
		mode_q <= `UMS_MODE_RST;
		baud_q <= `UMS_BAUD_RST;
	end else if (wr_done & hit_mode) begin
		mode_q <= pwdata[7:0];
	end else if (wr_done & hit_baud) begin
		baud_q <= pwdata[4:0];
	end
end

// ****************************************
// Receive line synchroniser
// ****************************************
always @(posedge clk) begin
	if (rst) begin
		rx_meta_q <= 1'b1;
		rx_sync_q <= 1'b1;
	end else begin
		rx_meta_q <= serial_rx_pin;
		rx_sync_q <= rx_meta_q;
	end
end

wire rx_in = power ? rx_sync_q : 1'b1;

// ****************************************
// Receiver
// ****************************************
wire [3:0] rx_nbits  = cl8 ? 4'd8 : 4'd7;
wire       rx_exp_p  = (par_sel == 2'b10) ? ~rx_par_q : rx_par_q;
wire [7:0] rx_char   = cl8 ? rx_sr_q : {1'b0, rx_sr_q[7:1]};
wire       rx_sample = (rx_cnt_q == bit_end);
reg        rx_fin;
reg  [2:0] rx_new_err;

always @(posedge clk) begin
	rx_fin     <= 1'b0;
	rx_new_err <= 3'b000;
	if (rx_rst) begin
		rx_state_q <= RX_IDLE;
		rx_cnt_q   <= 6'd0;
		rx_bit_q   <= 4'd0;
		rx_sr_q    <= 8'h00;
		rx_par_q   <= 1'b0;
	end else begin
		rx_cnt_q <= rx_cnt_q + 6'd1;
		case (rx_state_q)
			RX_IDLE: begin
				rx_cnt_q <= 6'd0;
				// A line already low at enable counts as a start bit
				if (!rx_in) begin
					rx_state_q <= RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == mid_pt) begin
					rx_cnt_q <= 6'd0;
					rx_bit_q <= 4'd0;
					rx_par_q <= 1'b0;
					rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_sample) begin
					rx_cnt_q <= 6'd0;
					rx_sr_q  <= {rx_in, rx_sr_q[7:1]};
					rx_par_q <= rx_par_q ^ rx_in;
					rx_bit_q <= rx_bit_q + 4'd1;
					if (rx_bit_q == rx_nbits - 4'd1) begin
						rx_state_q <= (par_sel == 2'b00) ? RX_STOP : RX_PARITY;
					end
				end
			end
			RX_PARITY: begin
				if (rx_sample) begin
					rx_cnt_q <= 6'd0;
					rx_par_q <= rx_par_q ^ rx_in;
					rx_state_q <= RX_STOP;
				end
			end
			RX_STOP: begin
				// Only one stop bit is ever checked, whatever the transmit setting
				if (rx_sample) begin
					rx_state_q <= RX_IDLE;
					rx_fin     <= 1'b1;
					rx_new_err[`UMS_ERR_FRAMING] <= ~rx_in;
					rx_new_err[`UMS_ERR_PARITY]  <= par_sel[1] & rx_exp_p;
					rx_new_err[`UMS_ERR_OVERRUN] <= rxbuf_full_q & ~rd_rxb;
				end
			end
			default: begin
				rx_state_q <= RX_IDLE;
			end
		endcase
	end
end

// Completed frame, unless it overruns, is latched one cycle after the stop sample, with its error flags
always @(posedge clk) begin
	if (pwr_rst) begin
		rxbuf_q      <= `UMS_BUF_RST;
		rxbuf_full_q <= 1'b0;
	end else if (rx_fin & ~rx_new_err[`UMS_ERR_OVERRUN] & rx_en) begin
		rxbuf_q      <= rx_char;
		rxbuf_full_q <= 1'b1;
	end else if (rd_rxb) begin
		rxbuf_full_q <= 1'b0;
	end
end

// Status flags: a new error in the cycle of a status read wins over the clear
wire [2:0] err_set = rx_fin ? rx_new_err : 3'b000;
always @(posedge clk) begin
	if (pwr_rst) begin
		err_q <= `UMS_ERR_RST;
	end else if (~rx_en) begin
		err_q <= `UMS_ERR_RST;
	end else if (rd_err) begin
		err_q <= err_set;
	end else begin
		err_q <= err_q | err_set;
	end
end

always @(posedge clk) begin
	if (rst) begin
		rx_err_irq  <= 1'b0;
		rx_done_irq <= 1'b0;
	end else begin
		rx_err_irq  <= rx_en & power & (|err_set);
		rx_done_irq <= rx_en & power & rx_fin & ~(|rx_new_err);
	end
end

// ****************************************
// Transmitter
// ****************************************
wire [7:0] tx_d      = pwdata[7:0];
wire       tx_xor    = cl8 ? ^tx_d : ^tx_d[6:0];
reg        tx_par;
reg  [9:0] tx_body;
reg  [3:0] tx_total;
always @* begin
	tx_par = 1'b0;
	if (par_sel == 2'b10) begin
		tx_par = ~tx_xor;
	end else if (par_sel == 2'b11) begin
		tx_par = tx_xor;
	end
	// Unused upper positions are filled with ones, which double as stop bits
	if (par_sel == 2'b00) begin
		tx_body = cl8 ? {2'b11, tx_d} : {3'b111, tx_d[6:0]};
	end else begin
		tx_body = cl8 ? {1'b1, tx_par, tx_d} : {2'b11, tx_par, tx_d[6:0]};
	end
	tx_total = 4'd2 + (cl8 ? 4'd8 : 4'd7) + {3'd0, (par_sel != 2'b00)} + {3'd0, sl2};
end

wire tx_busy = (tx_left_q != 4'd0);

always @(posedge clk) begin
	tx_done_irq <= 1'b0;
	if (tx_rst) begin
		tx_sr_q       <= 11'h7FF;
		tx_left_q     <= 4'd0;
		tx_cnt_q      <= 6'd0;
		serial_tx_pin <= 1'b1;
		txhold_q      <= `UMS_BUF_RST;
		if (rst) begin
			tx_done_irq <= 1'b0;
		end
	end else if (wr_txs & ~tx_busy) begin
		// Writes during a frame are dropped; software waits for the done pulse
		txhold_q      <= tx_d;
		tx_sr_q       <= {tx_body, 1'b0};
		tx_left_q     <= tx_total;
		tx_cnt_q      <= 6'd0;
	end else if (tx_busy) begin
		tx_cnt_q <= tx_cnt_q + 6'd1;
		if (tx_cnt_q == 6'd0) begin
			serial_tx_pin <= tx_sr_q[0];
		end
		if (tx_cnt_q == bit_end) begin
			tx_cnt_q  <= 6'd0;
			tx_sr_q   <= {1'b1, tx_sr_q[10:1]};
			tx_left_q <= tx_left_q - 4'd1;
			if (tx_left_q == 4'd1) begin
				tx_done_irq   <= 1'b1;
				serial_tx_pin <= 1'b1;
			end
		end
	end else begin
		serial_tx_pin <= 1'b1;
	end
end

endmodule

// ### testbench/ums_checker.sv
// Purpose: Port checks of the serial mode/status block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`include "ums_regs.vh"

// ****
// Checker
// ****
module ums_checker (
	input logic                   clk,
	input logic                   rst,
	input logic                   psel,
	input logic                   penable,
	input logic                   pwrite,
	input logic [`UMS_ADDR_W-1:0] paddr,
	input logic [31:0]            prdata,
	input logic                   pready,
	input logic                   pslverr,
	input logic                   serial_tx_pin,
	input logic                   rx_err_irq,
	input logic                   rx_done_irq,
	input logic                   tx_done_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire setup = psel && !penable;
	wire st    = paddr[19:2] == `UMS_IDX_RXERR;
	property p_tx_idle; $fell(rst) |-> serial_tx_pin; endproperty
	property p_stat_wait; setup && !pwrite && st |-> ##1 !pready ##1 !pready ##1 pready;
	endproperty
	property p_norm; setup && !st |-> ##1 !pready ##1 pready; endproperty
	property p_rdy_one; pready |=> !pready; endproperty
	property p_rdy_acc; pready |-> psel && penable; endproperty
	property p_err_rdy; pslverr |-> pready; endproperty
	property p_stat_zero; pready && st && !pwrite |-> prdata[31:3] == 0; endproperty
	property p_irq_one; rx_err_irq |=> !rx_err_irq; endproperty
	property p_irq_excl; !(rx_err_irq && rx_done_irq); endproperty
	property p_tx_end; tx_done_irq |-> serial_tx_pin; endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx not idle");
	a_stat_wait: assert property (p_stat_wait) else $error("status wait");
	a_norm: assert property (p_norm) else $error("access timing");
	a_rdy_one: assert property (p_rdy_one) else $error("ready width");
	a_rdy_acc: assert property (p_rdy_acc) else $error("stray ready");
	a_err_rdy: assert property (p_err_rdy) else $error("stray error");
	a_stat_zero: assert property (p_stat_zero) else $error("status high bits");
	a_irq_one: assert property (p_irq_one) else $error("irq width");
	a_irq_excl: assert property (p_irq_excl) else $error("irq clash");
	a_tx_end: assert property (p_tx_end) else $error("stop level");
	c_stat: cover property (setup && st);
	c_err: cover property (rx_err_irq);
	c_tx: cover property (tx_done_irq);
endmodule

// ### testbench/ums_partner.sv
// Purpose: Remote serial station
// Assumes: Idle-high lines, bit time in clock cycles
// Notes:   Keeps eleven samples of the last frame seen
`timescale 1ns/1ps

// ****
// Station
// ****
module ums_partner #(
	parameter BIT = 16
) (
	input  wire clk,
	input  wire line_in,
	output reg  line_out
);
	reg [10:0] cap;
	integer    i;
	initial line_out = 1'b1;
	task send(input [10:0] bits, input integer n);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int j = 0; j < n; j++) begin
			line_out <= bits[j];
			repeat (BIT) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask
	// Mid-bit sampling so edge jitter does not matter
	initial forever begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk);
		for (i = 0; i < 11; i = i + 1) begin
			cap[i] = line_in;
			repeat (BIT) @(posedge clk);
		end
	end
endmodule

// ### testbench/ums_top_tb.sv
// Purpose: Self-checking bench of the serial mode/status block
// Assumes: Divider at its minimum, so a bit is sixteen clocks
// Notes:   Remote station model sits on both serial pins
`timescale 1ns/1ps
`include "ums_regs.vh"

// ****
// Bench
// ****
module ums_top_tb;
	localparam BIT = 16;
	// Frames of 0xA6: no, zero, odd, even parity; two stops; seven bits
	localparam [47:0] TX_MODE = {8'hE1, 8'hE7, 8'hFD, 8'hF5, 8'hED, 8'hE5};
	localparam [23:0] TX_BITS = {4'd9, 4'd11, 4'd11, 4'd11, 4'd11, 4'd10};
	localparam [65:0] TX_CAP  = {11'h74C, 11'h74C, 11'h54C, 11'h74C, 11'h54C, 11'h74C};
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [19:0] paddr = 20'h0;
	reg  [31:0] pwdata = 32'h0;
	reg  [31:0] rd;
	reg         err;
	wire [31:0] prdata;
	wire        pready, pslverr, rx_line, tx_line, e_irq, t_irq, r_irq;
	integer     n_errors = 0;
	integer     tests_run = 0;
	integer     n_eirq = 0;
	integer     n_rirq = 0;
	always #5 clk = ~clk;
	// Interrupt pulses are counted so every frame outcome is seen once
	always @(posedge clk) begin
		if (e_irq === 1'b1) n_eirq <= n_eirq + 1;
		if (r_irq === 1'b1) n_rirq <= n_rirq + 1;
	end
	ums_top i_ums_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line),
		.rx_err_irq(e_irq), .tx_done_irq(t_irq), .rx_done_irq(r_irq));
	ums_partner #(.BIT(BIT)) i_ums_partner (.clk(clk), .line_in(tx_line), .line_out(rx_line));
	task chk(input [31:0] got, input [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input [17:0] idx, input w, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input [17:0] idx, input [31:0] exp);
		apb(idx, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	// Enables drop before frame settings move
	task setm(input [7:0] m);
		apb(`UMS_IDX_MODE, 1'b1, 32'h81);
		apb(`UMS_IDX_MODE, 1'b1, {24'h0, m & 8'h9F});
		apb(`UMS_IDX_MODE, 1'b1, {24'h0, m});
	endtask
	task rx(input [7:0] d, input p, input s);
		i_ums_partner.send({1'b0, s, p, d}, 10);
		repeat (8) @(posedge clk);
	endtask
	task t_reset;
		rchk(`UMS_IDX_MODE, 32'h01);
		apb(`UMS_IDX_RXERR, 1'b1, 32'h7);
		rchk(`UMS_IDX_RXERR, 32'h0);
		rchk(`UMS_IDX_RXBUF, 32'hFF);
		apb(18'h0FF75, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask
	task t_tx;
		integer p;
		integer n;
		for (p = 0; p < 6; p = p + 1) begin
			setm(TX_MODE[p*8 +: 8]);
			apb(`UMS_IDX_TXSHIFT, 1'b1, 32'hA6);
			for (n = 0; n < 400 && t_irq !== 1'b1; n = n + 1) @(posedge clk);
			chk(n, BIT * TX_BITS[p*4 +: 4] + 1);
			repeat (2 * BIT) @(posedge clk);
			chk({21'h0, i_ums_partner.cap}, {21'h0, TX_CAP[p*11 +: 11]});
		end
	endtask
	task t_rx;
		setm(8'hFD);
		rx(8'h3C, ^8'h3C, 1'b1);
		rchk(`UMS_IDX_RXERR, 32'h0);
		rchk(`UMS_IDX_RXBUF, 32'h3C);
		rx(8'h3C, ~^8'h3C, 1'b1);
		rchk(`UMS_IDX_RXERR, 32'h4);
		rchk(`UMS_IDX_RXERR, 32'h0);
		apb(`UMS_IDX_RXBUF, 1'b0, 32'h0);
		rx(8'h3C, ^8'h3C, 1'b0);
		rchk(`UMS_IDX_RXERR, 32'h2);
		apb(`UMS_IDX_RXBUF, 1'b0, 32'h0);
		rx(8'h55, ^8'h55, 1'b1);
		rx(8'h66, ^8'h66, 1'b1);
		rchk(`UMS_IDX_RXERR, 32'h1);
		rchk(`UMS_IDX_RXBUF, 32'h55);
		setm(8'hED);
		rx(8'h3C, 1'b1, 1'b1);
		rchk(`UMS_IDX_RXERR, 32'h0);
		rchk(`UMS_IDX_RXBUF, 32'h3C);
	endtask
	task t_off;
		setm(8'hE1);
		i_ums_partner.send({4'hF, 7'h2A}, 8);
		repeat (8) @(posedge clk);
		rchk(`UMS_IDX_RXBUF, 32'h2A);
		i_ums_partner.send({4'hE, 7'h2A}, 8);
		repeat (8) @(posedge clk);
		apb(`UMS_IDX_MODE, 1'b1, 32'h81);
		rchk(`UMS_IDX_RXERR, 32'h0);
		apb(`UMS_IDX_MODE, 1'b1, 32'h01);
		rchk(`UMS_IDX_RXERR, 32'h0);
		rchk(`UMS_IDX_RXBUF, 32'hFF);
		chk(n_eirq, 32'h4);
		chk(n_rirq, 32'h4);
	endtask
	task conclude;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#500000;
		n_errors = n_errors + 1;
		conclude;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		apb(`UMS_IDX_MODE, 1'b1, 32'h81);
		apb(`UMS_IDX_BAUD, 1'b1, 32'h08);
		t_tx;
		t_rx;
		t_off;
		conclude;
	end
endmodule

bind ums_top ums_checker i_ums_checker (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_tx_pin(serial_tx_pin), .rx_err_irq(rx_err_irq),
	.rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq));
